/* common/timer_two_defines.svh */
`ifndef TIMER_TWO_DEFINES_SVH
`define TIMER_TWO_DEFINES_SVH

`define TMR_OFS_CONTROL    8'hC8
`define TMR_OFS_RCAP_LOW   8'hCA
`define TMR_OFS_RCAP_HIGH  8'hCB
`define TMR_OFS_CNT_LOW    8'hCC
`define TMR_OFS_CNT_HIGH   8'hCD
`define TMR_OFS_IRQ_STATUS 8'hD0
`define TMR_OFS_IRQ_ENABLE 8'hD4
`define TMR_OFS_IRQ_CLEAR  8'hD8

`define TMR_BIT_OVF_FLAG   7
`define TMR_BIT_TRIG_FLAG  6
`define TMR_BIT_RX_SRC     5
`define TMR_BIT_TX_SRC     4
`define TMR_BIT_TRIG_EN    3
`define TMR_BIT_RUN        2
`define TMR_BIT_CT_SEL     1
`define TMR_BIT_CAP_SEL    0

`define TMR_IRQ_OVF        0
`define TMR_IRQ_TRIG       1

`define TMR_RST_BYTE       8'h00
`define TMR_RST_WORD       16'h0000
`define TMR_TIMER_DIV      2

`endif

/* common/timer_two_pkg.sv */
package timer_two_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] word_t;
	typedef logic [31:0] data_t;
	typedef enum logic [1:0] {
		EV_NONE,
		EV_RELOAD,
		EV_CAPTURE
	} trig_action_e;
endpackage

/* rtl/apb_byte_regs.sv */
`timescale 1ns/1ps
`include "timer_two_defines.svh"
module apb_byte_regs (
	input  wire logic                  sys_clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	output logic                       wr_stb_o,
	output logic                       rd_stb_o,
	output logic                       pready_o
);
	import timer_two_pkg::*;

	assign pready_o = 1'b1;
	assign wr_stb_o = psel_i & penable_i & pwrite_i;
	assign rd_stb_o = psel_i & penable_i & ~pwrite_i;
endmodule

/* rtl/fall_edge_detect.sv */
`timescale 1ns/1ps
module fall_edge_detect (
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	input  wire logic pin_i,
	output logic      fall_o
);
	logic prev_reg;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= pin_i;
		end
	end

	assign fall_o = prev_reg & ~pin_i;
endmodule

/* rtl/timer_two.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "timer_two_defines.svh"
module timer_two (
	input  wire logic                  sys_clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire timer_two_pkg::data_t  pwdata_i,
	output timer_two_pkg::data_t       prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  external_count_pin_i,
	input  wire logic                  capture_reload_trigger_pin_i,
	input  wire logic                  timer1_overflow_i,
	output logic                       serial_rx_clock_o,
	output logic                       serial_tx_clock_o,
	output logic                       irq_o
);
	import timer_two_pkg::*;

	byte_t        ctrl_reg;
	word_t        rcap_reg;
	word_t        cnt_reg;
	logic         div_reg;
	logic [1:0]   irq_st_reg;
	logic [1:0]   irq_en_reg;
	data_t        prdata_reg;
	logic         ovf_pulse_reg;
	logic         wr_stb;
	logic         rd_stb;
	logic         cnt_fall;
	logic         trig_fall;
	logic         serial_mode;
	logic         tick;
	logic         overflow;
	logic         reload_now;
	logic         capture_now;
	trig_action_e trig_act;
	word_t        cnt_next;

	apb_byte_regs u_bus (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.wr_stb_o  (wr_stb),
		.rd_stb_o  (rd_stb),
		.pready_o  (pready_o)
	);

	fall_edge_detect u_cnt_edge (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.pin_i     (external_count_pin_i),
		.fall_o    (cnt_fall)
	);

	fall_edge_detect u_trig_edge (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.pin_i     (capture_reload_trigger_pin_i),
		.fall_o    (trig_fall)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign pslverr_o = 1'b0;
	assign serial_mode = ctrl_reg[`TMR_BIT_RX_SRC] | ctrl_reg[`TMR_BIT_TX_SRC];

	// timer mode divider: one tick every two clocks
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl_reg[`TMR_BIT_RUN]) begin
			div_reg <= 1'b0;
		end else begin
			div_reg <= ~div_reg;
		end
	end

	always_comb begin
		if (!ctrl_reg[`TMR_BIT_RUN]) begin
			tick = 1'b0;
		end else if (ctrl_reg[`TMR_BIT_CT_SEL]) begin
			tick = cnt_fall;
		end else begin
			tick = div_reg;
		end
	end

	assign overflow = tick & (cnt_reg == 16'hFFFF);

	always_comb begin
		if (trig_fall && ctrl_reg[`TMR_BIT_TRIG_EN] && !serial_mode) begin
			trig_act = ctrl_reg[`TMR_BIT_CAP_SEL] ? EV_CAPTURE : EV_RELOAD;
		end else begin
			trig_act = EV_NONE;
		end
	end

	// overflow reload: in capture mode only while serial clocking forces it
	assign reload_now = (overflow && (!ctrl_reg[`TMR_BIT_CAP_SEL] || serial_mode))
		|| trig_act == EV_RELOAD;
	assign capture_now = (trig_act == EV_CAPTURE);

	always_comb begin
		if (reload_now) begin
			cnt_next = rcap_reg;
		end else if (tick) begin
			cnt_next = 16'(cnt_reg + 16'h0001);
		end else begin
			cnt_next = cnt_reg;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt_reg <= `TMR_RST_WORD;
		end else if (wr_stb && hit(paddr_i, `TMR_OFS_CNT_LOW)) begin
			cnt_reg <= {cnt_reg[15:8], pwdata_i[7:0]};
		end else if (wr_stb && hit(paddr_i, `TMR_OFS_CNT_HIGH)) begin
			cnt_reg <= {pwdata_i[7:0], cnt_reg[7:0]};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rcap_reg <= `TMR_RST_WORD;
		end else if (capture_now) begin
			rcap_reg <= cnt_reg;
		end else if (wr_stb && hit(paddr_i, `TMR_OFS_RCAP_LOW)) begin
			rcap_reg <= {rcap_reg[15:8], pwdata_i[7:0]};
		end else if (wr_stb && hit(paddr_i, `TMR_OFS_RCAP_HIGH)) begin
			rcap_reg <= {pwdata_i[7:0], rcap_reg[7:0]};
		end
	end

	// control: software write, hardware set wins
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl_reg <= `TMR_RST_BYTE;
		end else begin
			if (wr_stb && hit(paddr_i, `TMR_OFS_CONTROL)) begin
				ctrl_reg <= pwdata_i[7:0];
			end
			if (overflow && !serial_mode) begin
				ctrl_reg[`TMR_BIT_OVF_FLAG] <= 1'b1;
			end
			if (trig_act != EV_NONE) begin
				ctrl_reg[`TMR_BIT_TRIG_FLAG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ovf_pulse_reg <= 1'b0;
		end else begin
			ovf_pulse_reg <= overflow;
		end
	end

	assign serial_rx_clock_o = ctrl_reg[`TMR_BIT_RX_SRC] ? ovf_pulse_reg
		: timer1_overflow_i;
	assign serial_tx_clock_o = ctrl_reg[`TMR_BIT_TX_SRC] ? ovf_pulse_reg
		: timer1_overflow_i;

	// interrupt status: sticky, write-one-to-clear, set wins
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_st_reg <= 2'h0;
		end else begin
			if (wr_stb && hit(paddr_i, `TMR_OFS_IRQ_CLEAR)) begin
				irq_st_reg <= irq_st_reg & ~pwdata_i[1:0];
			end
			if (overflow && !serial_mode) begin
				irq_st_reg[`TMR_IRQ_OVF] <= 1'b1;
			end
			if (trig_act != EV_NONE) begin
				irq_st_reg[`TMR_IRQ_TRIG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_en_reg <= 2'h0;
		end else if (wr_stb && hit(paddr_i, `TMR_OFS_IRQ_ENABLE)) begin
			irq_en_reg <= pwdata_i[1:0];
		end
	end

	assign irq_o = |(irq_st_reg & irq_en_reg);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			if (hit(paddr_i, `TMR_OFS_CONTROL)) begin
				prdata_reg <= {24'h00_0000, ctrl_reg};
			end else if (hit(paddr_i, `TMR_OFS_RCAP_LOW)) begin
				prdata_reg <= {24'h00_0000, rcap_reg[7:0]};
			end else if (hit(paddr_i, `TMR_OFS_RCAP_HIGH)) begin
				prdata_reg <= {24'h00_0000, rcap_reg[15:8]};
			end else if (hit(paddr_i, `TMR_OFS_CNT_LOW)) begin
				prdata_reg <= {24'h00_0000, cnt_reg[7:0]};
			end else if (hit(paddr_i, `TMR_OFS_CNT_HIGH)) begin
				prdata_reg <= {24'h00_0000, cnt_reg[15:8]};
			end else if (hit(paddr_i, `TMR_OFS_IRQ_STATUS)) begin
				prdata_reg <= {30'h0000_0000, irq_st_reg};
			end else if (hit(paddr_i, `TMR_OFS_IRQ_ENABLE)) begin
				prdata_reg <= {30'h0000_0000, irq_en_reg};
			end else begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	assign prdata_o = prdata_reg;

	sequence s_run_tick;
		ctrl_reg[`TMR_BIT_RUN] && !ctrl_reg[`TMR_BIT_CT_SEL] && tick;
	endsequence

	sequence s_run_timer;
		ctrl_reg[`TMR_BIT_RUN] && !ctrl_reg[`TMR_BIT_CT_SEL];
	endsequence

	AST_OVF_FLAG: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		overflow && !serial_mode |=> ctrl_reg[`TMR_BIT_OVF_FLAG])
		else $error("overflow flag not set");
	AST_TRIG_FLAG: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		trig_act != EV_NONE |=> ctrl_reg[`TMR_BIT_TRIG_FLAG])
		else $error("trigger flag not set");
	AST_RX_SRC: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		overflow && ctrl_reg[`TMR_BIT_RX_SRC] && !wr_stb |=> serial_rx_clock_o)
		else $error("rx clock misses overflow");
	AST_TX_SRC: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		overflow && ctrl_reg[`TMR_BIT_TX_SRC] && !wr_stb |=> serial_tx_clock_o)
		else $error("tx clock misses overflow");
	AST_TRIG_IGNORED: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!ctrl_reg[`TMR_BIT_TRIG_EN] |-> trig_act == EV_NONE)
		else $error("trigger pin not ignored");
	AST_HALT: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!ctrl_reg[`TMR_BIT_RUN] && !wr_stb && trig_act != EV_RELOAD |=> $stable(cnt_reg))
		else $error("counter moved while stopped");
	AST_TIMER_RATE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		s_run_tick ##1 s_run_timer |-> !tick)
		else $error("timer ticks faster than half rate");
	AST_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		capture_now |=> rcap_reg == $past(cnt_reg))
		else $error("capture value wrong");
	AST_RELOAD: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		overflow && serial_mode && !wr_stb |=> cnt_reg == $past(rcap_reg))
		else $error("forced reload missing");
endmodule

/* sim/far_side.sv */
`timescale 1ns/1ps
module far_side (
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic       count_req_i,
	input  wire logic       trig_req_i,
	input  wire logic       rx_clock_i,
	input  wire logic       tx_clock_i,
	output logic            count_pin_o,
	output logic            trig_pin_o,
	output logic            timer1_ovf_o,
	output logic [7:0]      rx_ticks_o,
	output logic [7:0]      tx_ticks_o,
	output logic [7:0]      t1_ticks_o
);
	logic [1:0] count_low_reg;
	logic [1:0] trig_low_reg;
	logic [1:0] t1_div_reg;
	// pins idle high, pulled low for three cycles per requested edge
	assign count_pin_o  = (count_low_reg == 2'h0);
	assign trig_pin_o   = (trig_low_reg == 2'h0);
	assign timer1_ovf_o = (t1_div_reg == 2'h3);
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			count_low_reg <= 2'h0;
			trig_low_reg  <= 2'h0;
			t1_div_reg    <= 2'h0;
		end else begin
			count_low_reg <= count_req_i ? 2'h3 : count_low_reg - {1'b0, count_low_reg != 2'h0};
			trig_low_reg  <= trig_req_i ? 2'h3 : trig_low_reg - {1'b0, trig_low_reg != 2'h0};
			t1_div_reg    <= t1_div_reg + 2'h1;
		end
	end
	// serial port side counts baud pulses of each clock
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rx_ticks_o <= 8'h00;
			tx_ticks_o <= 8'h00;
			t1_ticks_o <= 8'h00;
		end else begin
			rx_ticks_o <= rx_ticks_o + {7'h00, rx_clock_i};
			tx_ticks_o <= tx_ticks_o + {7'h00, tx_clock_i};
			t1_ticks_o <= t1_ticks_o + {7'h00, timer1_ovf_o};
		end
	end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
	import timer_two_pkg::*;
	logic        sys_clk   = 1'b0;
	logic        srst      = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	data_t       pwdata    = 32'h0000_0000;
	logic        count_req = 1'b0;
	logic        trig_req  = 1'b0;
	data_t       prdata;
	logic        pready;
	logic        count_pin;
	logic        trig_pin;
	logic        t1_ovf;
	logic        rx_clk;
	logic        tx_clk;
	logic        irq;
	byte_t       rx_ticks;
	byte_t       tx_ticks;
	byte_t       t1_ticks;
	byte_t       r;
	byte_t       r2;
	int          n_mismatch = 0;
	int          compares   = 0;
	byte_t       rst_addr[6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0};

	always #20 sys_clk = ~sys_clk;

	timer_two timer_two_inst (.sys_clk_i(sys_clk), .srst_i(srst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(), .external_count_pin_i(count_pin),
		.capture_reload_trigger_pin_i(trig_pin), .timer1_overflow_i(t1_ovf),
		.serial_rx_clock_o(rx_clk), .serial_tx_clock_o(tx_clk), .irq_o(irq));
	far_side far_side_inst (.sys_clk_i(sys_clk), .srst_i(srst), .count_req_i(count_req),
		.trig_req_i(trig_req), .rx_clock_i(rx_clk), .tx_clock_i(tx_clk),
		.count_pin_o(count_pin), .trig_pin_o(trig_pin), .timer1_ovf_o(t1_ovf),
		.rx_ticks_o(rx_ticks), .tx_ticks_o(tx_ticks), .t1_ticks_o(t1_ticks));

	task automatic close_out;
		$display("counts: compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input byte_t seen, input byte_t exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input byte_t addr, input byte_t wd, output byte_t rd);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= {24'h00_0000, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata[7:0];
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("mismatch at %0t: no ready", $time);
			close_out();
		end
		@(posedge sys_clk);
	endtask

	task automatic wr(input byte_t a, input byte_t d);
		byte_t x;
		apb(1'b1, a, d, x);
	endtask

	task automatic rd_chk(input byte_t a, input byte_t e);
		byte_t x;
		apb(1'b0, a, 8'h00, x);
		check(x, e);
	endtask

	task automatic fall(input logic trig);
		if (trig) trig_req <= 1'b1;
		else count_req <= 1'b1;
		@(posedge sys_clk);
		trig_req  <= 1'b0;
		count_req <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		foreach (rst_addr[i]) rd_chk(rst_addr[i], 8'h00);
		check({7'h00, irq}, 8'h00);
		wr(8'hCA, 8'h5A);
		wr(8'hCB, 8'hA5);
		wr(8'hC0, 8'hFF);
		rd_chk(8'hCA, 8'h5A);
		rd_chk(8'hCB, 8'hA5);
		rd_chk(8'hC0, 8'h00);
		$display("test registers done");
		wr(8'hC8, 8'h04);
		repeat (40) @(posedge sys_clk);
		wr(8'hC8, 8'h00);
		apb(1'b0, 8'hCC, 8'h00, r);
		check(r, 8'h15);
		repeat (10) @(posedge sys_clk);
		apb(1'b0, 8'hCC, 8'h00, r2);
		check(r2, r);
		$display("test timer done");
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFF);
		wr(8'hD4, 8'h03);
		rd_chk(8'hD4, 8'h03);
		wr(8'hC8, 8'h06);
		check({7'h00, irq}, 8'h00);
		fall(1'b0);
		rd_chk(8'hCC, 8'h34);
		rd_chk(8'hCD, 8'h12);
		rd_chk(8'hC8, 8'h86);
		rd_chk(8'hD0, 8'h01);
		check({7'h00, irq}, 8'h01);
		fall(1'b0);
		fall(1'b0);
		rd_chk(8'hCC, 8'h36);
		wr(8'hD8, 8'h01);
		check({7'h00, irq}, 8'h00);
		wr(8'hC8, 8'h06);
		rd_chk(8'hC8, 8'h06);
		$display("test overflow done");
		wr(8'hC8, 8'h0F);
		fall(1'b1);
		rd_chk(8'hCA, 8'h36);
		rd_chk(8'hC8, 8'h4F);
		rd_chk(8'hD0, 8'h02);
		check({7'h00, irq}, 8'h01);
		wr(8'hD8, 8'h02);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFF);
		fall(1'b0);
		rd_chk(8'hCC, 8'h00);
		rd_chk(8'hCD, 8'h00);
		rd_chk(8'hC8, 8'hCF);
		$display("test capture done");
		wr(8'hC8, 8'h06);
		fall(1'b1);
		rd_chk(8'hC8, 8'h06);
		rd_chk(8'hCC, 8'h00);
		wr(8'hC8, 8'h0E);
		fall(1'b1);
		rd_chk(8'hCC, 8'h36);
		rd_chk(8'hCD, 8'h12);
		rd_chk(8'hC8, 8'h4E);
		$display("test trigger done");
		wr(8'hC8, 8'h27);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFF);
		r = rx_ticks;
		fall(1'b0);
		rd_chk(8'hCC, 8'h36);
		rd_chk(8'hC8, 8'h27);
		check(rx_ticks, byte_t'(r + 8'h01));
		check(tx_ticks, t1_ticks);
		wr(8'hC8, 8'h2F);
		wr(8'hCC, 8'h00);
		fall(1'b1);
		rd_chk(8'hC8, 8'h2F);
		rd_chk(8'hCC, 8'h00);
		wr(8'hC8, 8'h17);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFF);
		r = tx_ticks;
		fall(1'b0);
		check(tx_ticks, byte_t'(r + 8'h01));
		rd_chk(8'hCC, 8'h36);
		rd_chk(8'hC8, 8'h17);
		$display("test serial done");
		close_out();
	end
endmodule
